// ### shared/pmc_regs.svh
/*
 * Offsets, field positions, reset values and counts of the perf monitor control block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// ----------------------------------------------------------------
// register offsets on the external debug interface
// ----------------------------------------------------------------
`define PMC_ADDR_W 12
`define PMC_AUTH_OFFSET 12'h0f8
`define PMC_CTRL_OFFSET 12'he04

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define PMC_CTRL_E 0
`define PMC_CTRL_P 1
`define PMC_CTRL_C 2
`define PMC_CTRL_D 3
`define PMC_CTRL_X 4
`define PMC_CTRL_DP 5
`define PMC_CTRL_LC 6
`define PMC_SHARED_W 7

// ----------------------------------------------------------------
// reset values (long-counter bit is architecturally unknown)
// ----------------------------------------------------------------
`define PMC_LC_RESET 1'h1
`define PMC_DP_RESET 1'h0
`define PMC_X_RESET 1'h0
`define PMC_D_RESET 1'h0
`define PMC_E_RESET 1'h0

// ----------------------------------------------------------------
// sizes and counts
// ----------------------------------------------------------------
`define PMC_PRESCALE_DIV 64
`define PMC_PRESCALE_W 6
`define PMC_NUM_EVT 31
`define PMC_HPMN_W 5
`define PMC_EVT_BUS_W 8
`define PMC_CYC_W 64
`define PMC_SHORT_OVF_BIT 31
`define PMC_LONG_OVF_BIT 63

`endif

// ### shared/pmc_pkg.sv
/*
 * Types of the perf monitor control block.
 * Assumes pmc_regs.svh on the include path.
 */
`include "pmc_regs.svh"

package pmc_pkg;

    typedef struct packed {
        logic lc;
        logic dp;
        logic x;
        logic d;
        logic e;
        logic [`PMC_CYC_W-1:0] cyc;
        logic ovf;
        logic [`PMC_NUM_EVT-1:0] evt_clr;
        logic [`PMC_EVT_BUS_W-1:0] evt_out;
        logic [31:0] rdata;
        logic rvalid;
    } pmc_state_t;

    typedef struct packed {
        logic [`PMC_PRESCALE_W-1:0] cnt;
        logic tick;
    } pmc_pre_state_t;

endpackage : pmc_pkg

// ### verilog/pmc_sync2.sv
/*
 * Two-flop level synchroniser, width set by parameter.
 * Assumes a level input from outside the clock domain.
 */
`timescale 1ns/1ps

module pmc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } pmc_sync_state_t;

    pmc_sync_state_t s;
    pmc_sync_state_t next_s;

    always_comb
    begin
        next_s.meta = din;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    assign dout = s.stable;

endmodule : pmc_sync2

// ### verilog/pmc_prescale.sv
/*
 * Divide-by-64 prescaler for the cycle counter.
 * Assumes run is a same-clock enable; tick is one cycle every 64 run cycles.
 */
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_prescale
    import pmc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    output logic tick
);

    pmc_pre_state_t s;
    pmc_pre_state_t next_s;

    always_comb
    begin
        next_s = s;
        next_s.tick = 1'b0;
        if (run)
        begin
            next_s.cnt = s.cnt + `PMC_PRESCALE_W'(1);
            next_s.tick = (s.cnt == `PMC_PRESCALE_W'(`PMC_PRESCALE_DIV - 1));
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            s <= '0;
        else
            s <= next_s;
    end

    // combinational so the counter steps in the same cycle as the 64th run
    assign tick = run && (s.cnt == `PMC_PRESCALE_W'(`PMC_PRESCALE_DIV - 1));

endmodule : pmc_prescale

// ### verilog/pmc_top.sv
/*
 * Perf monitor control and authentication status words, with the cycle counter they steer.
 * Assumes a single-cycle external debug access port and a processor system-register port on clk.
 */
// Behaviour
// - hypervisor-invasive and secure non-invasive auth fields read 00.
// - secure-invasive and non-secure-invasive auth fields read 00; upper bits zero.
// - hypervisor and non-secure non-invasive auth fields mirror debug auth status.
// - low seven control bits are one storage for both views.
// - control word resets on warm/cold reset only, not debug reset.
// - upper control bits read zero, writes ignored; software does read-modify-write.
// - overflow when bit 31 or bit 63 (long-counter) goes 1 to 0.
// - stop-when-prohibited halts cycle counter while prohibited; zero without hypervisor.
// - export bit sends events when not prohibited; fixed when no event bus.
// - no export while prohibited; export bit does not touch overflow signalling.
// - divider bit counts cycle counter once per 64 clocks.
// - long-counter set ignores divider, counts every clock.
// - cycle-reset write clears cycle counter, keeps overflow flag, reads zero.
// - event-reset write clears event counters, not overflow flags, reads zero.
// - with hypervisor external-access bit, event reset spares hypervisor counters.
// - global enable 0 stops lower-level counters including cycle counter.
// - global enable 1 follows individual enables, subject to hypervisor prohibit.
// - global enable does not affect hypervisor-reserved counters.
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_top
    import pmc_pkg::*;
#(
    parameter bit HYP_PRESENT = 1'b1,
    parameter bit EVENT_BUS_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic dbg_rst,
    input wire logic ext_sel,
    input wire logic ext_wr,
    input wire logic [`PMC_ADDR_W-1:0] ext_addr,
    input wire logic [31:0] ext_wdata,
    output logic [31:0] ext_rdata,
    output logic ext_rvalid,
    input wire logic sys_wr,
    input wire logic [`PMC_SHARED_W-1:0] sys_wdata,
    output logic [`PMC_SHARED_W-1:0] sys_rdata,
    input wire logic [1:0] hyp_noninvasive_field,
    input wire logic [1:0] nonsecure_noninvasive_field,
    input wire logic count_prohibited,
    input wire logic hyp_prohibit_bit,
    input wire logic hyp_external_access_bit,
    input wire logic [`PMC_HPMN_W-1:0] hyp_partition_field,
    input wire logic cycle_enable_set,
    input wire logic [`PMC_NUM_EVT-1:0] per_counter_enable_set,
    input wire logic [`PMC_EVT_BUS_W-1:0] evt_in,
    output logic [`PMC_EVT_BUS_W-1:0] evt_export,
    output logic [`PMC_NUM_EVT-1:0] evt_count_enable,
    output logic [`PMC_NUM_EVT-1:0] evt_counter_clear,
    output logic [`PMC_CYC_W-1:0] cycle_counter,
    output logic cycle_overflow
);

    // ----------------------------------------------------------------
    // state and synchronised authentication levels
    // ----------------------------------------------------------------
    pmc_state_t s;
    pmc_state_t next_s;
    logic [1:0] hyp_noninvasive_field_s;
    logic [1:0] nonsecure_noninvasive_field_s;
    logic tick;
    logic cyc_run;
    logic cyc_step;
    logic ext_rd;
    logic ext_wr_ctrl;
    logic [`PMC_SHARED_W-1:0] ctrl_low;
    logic [31:0] auth_word;
    logic [31:0] ctrl_word;
    logic [`PMC_CYC_W-1:0] cyc_inc;
    logic clear_cyc;
    logic clear_evt;

    pmc_sync2 #(.W(4)) u_auth_sync (
        .clk(clk),
        .rst(rst),
        .din({hyp_noninvasive_field, nonsecure_noninvasive_field}),
        .dout({hyp_noninvasive_field_s, nonsecure_noninvasive_field_s})
    );

    // ----------------------------------------------------------------
    // register views
    // ----------------------------------------------------------------
    assign ext_rd = ext_sel && !ext_wr;
    assign ext_wr_ctrl = ext_sel && ext_wr && (ext_addr == `PMC_CTRL_OFFSET);

    // reset and clear bits never hold state, so they read zero in both views
    assign ctrl_low = {s.lc, s.dp, s.x, s.d, 1'b0, 1'b0, s.e};
    assign ctrl_word = {25'h0, ctrl_low};
    // unimplemented debug classes are hard-wired to 00
    assign auth_word = {20'h0, hyp_noninvasive_field_s, 2'h0, 2'h0, 2'h0, nonsecure_noninvasive_field_s, 2'h0};

    assign clear_cyc = (ext_wr_ctrl && ext_wdata[`PMC_CTRL_C]) || (sys_wr && sys_wdata[`PMC_CTRL_C]);
    assign clear_evt = (ext_wr_ctrl && ext_wdata[`PMC_CTRL_P]) || (sys_wr && sys_wdata[`PMC_CTRL_P]);

    // ----------------------------------------------------------------
    // counting enables
    // ----------------------------------------------------------------
    // cycle counter is never hypervisor-reserved, so the global enable always gates it
    assign cyc_run = s.e && cycle_enable_set
        && !(s.dp && (count_prohibited || hyp_prohibit_bit));

    pmc_prescale u_prescale (
        .clk(clk),
        .rst(rst),
        .run(cyc_run && s.d && !s.lc),
        .tick(tick)
    );

    // divider is ignored once the long counter is selected
    assign cyc_step = cyc_run && (s.lc || !s.d || tick);
    assign cyc_inc = s.cyc + `PMC_CYC_W'(1);

    always_comb
    begin
        for (int i = 0; i < `PMC_NUM_EVT; i++)
        begin
            if (HYP_PRESENT && (i >= int'(hyp_partition_field)))
                evt_count_enable[i] = per_counter_enable_set[i];
            else
                evt_count_enable[i] = s.e && per_counter_enable_set[i]
                    && !hyp_prohibit_bit && !count_prohibited;
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.ovf = 1'b0;
        next_s.rvalid = 1'b0;
        next_s.evt_clr = '0;
        // control word: the system view wins a same-cycle collision on shared bits
        if (ext_wr_ctrl)
        begin
            next_s.lc = ext_wdata[`PMC_CTRL_LC];
            next_s.dp = HYP_PRESENT && ext_wdata[`PMC_CTRL_DP];
            next_s.x = EVENT_BUS_PRESENT && ext_wdata[`PMC_CTRL_X];
            next_s.d = ext_wdata[`PMC_CTRL_D];
            next_s.e = ext_wdata[`PMC_CTRL_E];
        end
        if (sys_wr)
        begin
            next_s.lc = sys_wdata[`PMC_CTRL_LC];
            next_s.dp = HYP_PRESENT && sys_wdata[`PMC_CTRL_DP];
            next_s.x = EVENT_BUS_PRESENT && sys_wdata[`PMC_CTRL_X];
            next_s.d = sys_wdata[`PMC_CTRL_D];
            next_s.e = sys_wdata[`PMC_CTRL_E];
        end
        // cycle counter: clearing beats counting and never sets the overflow flag
        if (clear_cyc)
            next_s.cyc = '0;
        else if (cyc_step)
        begin
            next_s.cyc = cyc_inc;
            if (s.lc)
                next_s.ovf = s.cyc[`PMC_LONG_OVF_BIT] && !cyc_inc[`PMC_LONG_OVF_BIT];
            else
                next_s.ovf = s.cyc[`PMC_SHORT_OVF_BIT] && !cyc_inc[`PMC_SHORT_OVF_BIT];
        end
        // event counter clear strobes, overflow flags live elsewhere and are left alone
        if (clear_evt)
        begin
            for (int i = 0; i < `PMC_NUM_EVT; i++)
                next_s.evt_clr[i] = !(HYP_PRESENT && hyp_external_access_bit
                    && (i >= int'(hyp_partition_field)));
        end
        // export gate is independent of the overflow path above
        next_s.evt_out = (s.x && !count_prohibited) ? evt_in : '0;
        // read port: unmapped addresses answer zero
        if (ext_rd)
        begin
            next_s.rvalid = 1'b1;
            if (ext_addr == `PMC_AUTH_OFFSET)
                next_s.rdata = auth_word;
            else if (ext_addr == `PMC_CTRL_OFFSET)
                next_s.rdata = ctrl_word;
            else
                next_s.rdata = '0;
        end
        // debug reset only flushes the read port, the control word survives it
        if (dbg_rst)
        begin
            next_s.rdata = '0;
            next_s.rvalid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.lc <= `PMC_LC_RESET;
            s.dp <= `PMC_DP_RESET;
            s.x <= `PMC_X_RESET;
            s.d <= `PMC_D_RESET;
            s.e <= `PMC_E_RESET;
        end
        else
            s <= next_s;
    end

    assign ext_rdata = s.rdata;
    assign ext_rvalid = s.rvalid;
    assign sys_rdata = ctrl_low;
    assign evt_export = s.evt_out;
    assign evt_counter_clear = s.evt_clr;
    assign cycle_counter = s.cyc;
    assign cycle_overflow = s.ovf;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_AUTH_HID_SECURE_NONINVASIVE_FIELD: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_AUTH_OFFSET) |=> (ext_rdata[9:6] == 4'h0 && ext_rvalid))
        else $error("hyp invasive or secure non-invasive field not zero");

    AST_AUTH_RES0: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_AUTH_OFFSET)
        |=> (ext_rdata[31:12] == 20'h0 && ext_rdata[5:4] == 2'h0 && ext_rdata[1:0] == 2'h0))
        else $error("auth status reserved or invasive field not zero");

    AST_AUTH_MIRROR: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_AUTH_OFFSET)
        |=> (ext_rdata[11:10] == $past(hyp_noninvasive_field_s) && ext_rdata[3:2] == $past(nonsecure_noninvasive_field_s)))
        else $error("auth status does not mirror debug auth levels");

    AST_SHARED_VIEW: assert property (@(posedge clk) disable iff (rst)
        (ext_wr_ctrl && !sys_wr) |=> (sys_rdata[`PMC_CTRL_E] == $past(ext_wdata[`PMC_CTRL_E])
        && sys_rdata[`PMC_CTRL_D] == $past(ext_wdata[`PMC_CTRL_D])
        && sys_rdata[`PMC_CTRL_LC] == $past(ext_wdata[`PMC_CTRL_LC])))
        else $error("external write not visible in system view");

    AST_DBG_RST_KEEPS: assert property (@(posedge clk) disable iff (rst)
        (dbg_rst && !ext_wr_ctrl && !sys_wr) |=> $stable(ctrl_low))
        else $error("control word changed by debug reset");

    AST_CTRL_UPPER_ZERO: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_CTRL_OFFSET) |=> (ext_rdata[31:7] == 25'h0))
        else $error("upper control bits not zero");

    AST_OVF_CAUSE: assert property (@(posedge clk) disable iff (rst)
        cycle_overflow |-> ($past(s.lc) ? ($past(s.cyc[63]) && !s.cyc[63]) : ($past(s.cyc[31]) && !s.cyc[31])))
        else $error("overflow without the selected bit wrapping");

    AST_DP_HALT: assert property (@(posedge clk) disable iff (rst)
        (s.dp && count_prohibited && !clear_cyc) |=> $stable(cycle_counter))
        else $error("cycle counter moved while prohibited");

    AST_EXPORT_QUIET: assert property (@(posedge clk) disable iff (rst)
        (count_prohibited || !s.x) |=> (evt_export == '0))
        else $error("events exported while prohibited or disabled");

    AST_DIV_HOLD: assert property (@(posedge clk) disable iff (rst)
        (s.d && !s.lc && !tick && !clear_cyc) |=> $stable(cycle_counter))
        else $error("divided cycle counter stepped off its tick");

    AST_LONG_EVERY: assert property (@(posedge clk) disable iff (rst)
        (s.lc && cyc_run && !clear_cyc) |=> (cycle_counter == $past(cycle_counter) + 64'h1))
        else $error("long counter did not count every clock");

    AST_CYC_CLEAR: assert property (@(posedge clk) disable iff (rst)
        clear_cyc |=> (cycle_counter == '0 && !cycle_overflow))
        else $error("cycle reset did not clear counter");

    AST_EVT_CLEAR: assert property (@(posedge clk) disable iff (rst)
        (clear_evt && !(HYP_PRESENT && hyp_external_access_bit)) |=> (evt_counter_clear == '1))
        else $error("event reset did not clear every counter");

    AST_ENABLE_OFF: assert property (@(posedge clk) disable iff (rst)
        (!s.e && !clear_cyc) |=> $stable(cycle_counter))
        else $error("cycle counter moved with global enable off");

    AST_DP_OFF_COUNTS: assert property (@(posedge clk) disable iff (rst)
        (!s.dp && s.e && cycle_enable_set && s.lc && !clear_cyc) |=> (cycle_counter == $past(cycle_counter) + 64'h1))
        else $error("cycle counter stopped although stop-when-prohibited is off");

    AST_EXPORT_PASS: assert property (@(posedge clk) disable iff (rst)
        (s.x && !count_prohibited) |=> (evt_export == $past(evt_in)))
        else $error("enabled export did not pass events through");

    AST_DIV_TICK: assert property (@(posedge clk) disable iff (rst)
        (s.d && !s.lc && cyc_run && tick && !clear_cyc) |=> (cycle_counter == $past(cycle_counter) + 64'h1))
        else $error("divided cycle counter missed its tick");

    AST_SYS_WINS: assert property (@(posedge clk) disable iff (rst)
        sys_wr |=> (sys_rdata[`PMC_CTRL_E] == $past(sys_wdata[`PMC_CTRL_E])
        && sys_rdata[`PMC_CTRL_D] == $past(sys_wdata[`PMC_CTRL_D])))
        else $error("system write not visible in shared bits");

    AST_CTRL_READBACK: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_CTRL_OFFSET) |=> (ext_rdata[6:0] == $past(sys_rdata)))
        else $error("external read differs from system view");

    AST_CTRL_WO_BITS: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst && ext_addr == `PMC_CTRL_OFFSET)
        |=> (ext_rdata[`PMC_CTRL_C] == 1'b0 && ext_rdata[`PMC_CTRL_P] == 1'b0))
        else $error("write-one reset bits did not read zero");

    // read answers come exactly one cycle after the strobe, never for a write
    AST_READ_ANSWER: assert property (@(posedge clk) disable iff (rst)
        (ext_rd && !dbg_rst) |=> ext_rvalid)
        else $error("read got no answer");

    AST_WRITE_SILENT: assert property (@(posedge clk) disable iff (rst)
        (!ext_rd || dbg_rst) |=> !ext_rvalid)
        else $error("answer without a read");

    AST_DBG_RST_CANCEL: assert property (@(posedge clk) disable iff (rst)
        dbg_rst |=> (!ext_rvalid && ext_rdata == 32'h0))
        else $error("debug reset did not flush the read port");

    AST_EVT_IDLE: assert property (@(posedge clk) disable iff (rst)
        !clear_evt |=> (evt_counter_clear == '0))
        else $error("event clear strobe without a write");

    AST_EVT_SPARE: assert property (@(posedge clk) disable iff (rst)
        (clear_evt && HYP_PRESENT && hyp_external_access_bit) |=> ((evt_counter_clear >> $past(hyp_partition_field)) == '0))
        else $error("event reset touched hypervisor counters");

    // counter 0 sits below any nonzero partition, so it stands for the lower group
    AST_ENABLE_OFF_LOW: assert property (@(posedge clk) disable iff (rst)
        (!s.e && hyp_partition_field != 5'h00) |-> !evt_count_enable[0])
        else $error("lower counter enabled with global enable off");

    AST_HYP_PROHIBIT_LOW: assert property (@(posedge clk) disable iff (rst)
        (hyp_prohibit_bit && hyp_partition_field != 5'h00) |-> !evt_count_enable[0])
        else $error("lower counter enabled while hypervisor prohibits");

    // counter 30 is reserved whenever the partition leaves it above
    AST_HYP_FREE: assert property (@(posedge clk) disable iff (rst)
        (HYP_PRESENT && hyp_partition_field <= 5'h1e) |-> (evt_count_enable[30] == per_counter_enable_set[30]))
        else $error("reserved counter gated by global controls");

endmodule : pmc_top

// ### tb/pmc_dbg_model.sv
/*
 * External debugger model on the debug access port of the perf monitor control block.
 * Assumes one caller process on clk; every access is a single whole 32-bit word.
 */
`timescale 1ns/1ps
`include "pmc_regs.svh"

module pmc_dbg_model
    import pmc_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] ext_rdata,
    input wire logic ext_rvalid,
    output logic ext_sel,
    output logic ext_wr,
    output logic [`PMC_ADDR_W-1:0] ext_addr,
    output logic [31:0] ext_wdata
);
    initial
    begin
        ext_sel = 1'h0;
        ext_wr = 1'h0;
        ext_addr = 12'h000;
        ext_wdata = 32'h00000000;
    end

    // ----------------------------------------------------------------
    // access cycle
    // ----------------------------------------------------------------
    // released lines show the inverse so a stale value never passes
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        ext_sel <= 1'h1;
        ext_wr <= w;
        ext_addr <= a;
        ext_wdata <= d;
        @(posedge clk);
        ext_sel <= 1'h0;
        ext_wr <= ~w;
        ext_addr <= ~a;
        ext_wdata <= ~d;
    endtask : acc

    task wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'h1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, output logic [31:0] q);
        int i;
        acc(1'h0, a, 32'h00000000);
        i = 0;
        do
        begin
            @(posedge clk);
            i++;
        end
        while (ext_rvalid !== 1'b1 && i < 4);
        q = ext_rdata;
    endtask : rd

    // never assumes the upper bits read zero
    task rmw(input logic [11:0] a, input logic [31:0] clr, input logic [31:0] set);
        logic [31:0] q;
        rd(a, q);
        wr(a, (q & ~clr) | set);
    endtask : rmw
endmodule : pmc_dbg_model

// ### tb/perf_monitor_control_regs_bench.sv
/*
 * Self-checking bench of the perf monitor control block.
 * Assumes default parameters: hypervisor level and event bus present.
 */
`timescale 1ns/1ps
`include "pmc_regs.svh"

module perf_monitor_control_regs_bench
    import pmc_pkg::*;
;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic dbg_rst = 1'h0;
    logic sys_wr = 1'h0;
    logic [6:0] sys_wdata = 7'h00;
    logic [1:0] hyp_noninvasive_field = 2'h0;
    logic [1:0] nonsecure_noninvasive_field = 2'h0;
    logic count_prohibited = 1'h0;
    logic hyp_prohibit_bit = 1'h0;
    logic hyp_external_access_bit = 1'h0;
    logic [4:0] hyp_partition_field = 5'h05;
    logic cycle_enable_set = 1'h1;
    logic [30:0] per_counter_enable_set = 31'h00000000;
    logic [7:0] evt_in = 8'h00;
    logic ext_sel, ext_wr, ext_rvalid, cycle_overflow;
    logic [11:0] ext_addr;
    logic [31:0] ext_wdata, ext_rdata, r, rv;
    logic [6:0] sys_rdata, ctl;
    logic [7:0] evt_export;
    logic [30:0] evt_count_enable, evt_counter_clear;
    logic [63:0] cycle_counter;
    logic [31:0] exq[$];
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;

    always #2 clk = ~clk;

    pmc_top u_dut (.clk, .rst, .dbg_rst, .ext_sel, .ext_wr, .ext_addr, .ext_wdata, .ext_rdata,
        .ext_rvalid, .sys_wr, .sys_wdata, .sys_rdata, .hyp_noninvasive_field,
        .nonsecure_noninvasive_field, .count_prohibited, .hyp_prohibit_bit, .hyp_external_access_bit,
        .hyp_partition_field, .cycle_enable_set, .per_counter_enable_set, .evt_in, .evt_export,
        .evt_count_enable, .evt_counter_clear, .cycle_counter, .cycle_overflow);

    pmc_dbg_model u_dbg (.clk, .ext_rdata, .ext_rvalid, .ext_sel, .ext_wr, .ext_addr, .ext_wdata);

    // ----------------------------------------------------------------
    // compare, report
    // ----------------------------------------------------------------
    task cmp(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp

    task end_sim();
        $display("errors %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim

    always @(negedge clk)
    begin
        if (ext_rvalid === 1'b1)
        begin
            if (exq.size() == 0)
                cmp(64'h1, 64'h0);
            else
                cmp(ext_rdata, exq.pop_front());
        end
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            bad_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // stimulus helpers
    // ----------------------------------------------------------------
    task rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        exq.push_back(e);
        u_dbg.rd(a, q);
    endtask : rd_chk

    // random upper bits must be ignored
    task w(input logic [6:0] v);
        r = $urandom();
        ctl = v & 7'h79;
        u_dbg.wr(`PMC_CTRL_OFFSET, {r[31:7], v});
    endtask : w

    task delta(input int n, input logic [63:0] e);
        logic [63:0] a;
        @(negedge clk);
        a = cycle_counter;
        repeat (n) @(negedge clk);
        cmp(cycle_counter - a, e);
    endtask : delta

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        void'($urandom(53278));
        repeat (2) @(posedge clk);
        rv = $urandom();
        rst <= 1'h0;
        hyp_noninvasive_field <= rv[1:0];
        nonsecure_noninvasive_field <= rv[3:2];
        evt_in <= rv[15:8];
        per_counter_enable_set <= {rv[30:5], 5'h1f};
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp(sys_rdata, 7'h40);
        rd_chk(`PMC_CTRL_OFFSET, 32'h00000040);
        u_dbg.wr(`PMC_AUTH_OFFSET, 32'hffffffff);
        rd_chk(`PMC_AUTH_OFFSET, {20'h0, rv[1:0], 6'h00, rv[3:2], 2'h0});
        rd_chk(12'h100, 32'h00000000);
        w(7'h7f);
        @(negedge clk);
        cmp(evt_counter_clear, 31'h7fffffff);
        cmp(cycle_counter, 64'h0);
        cmp(cycle_overflow, 1'h0);
        rd_chk(`PMC_CTRL_OFFSET, 32'h00000079);
        delta(100, 64'd100);
        @(posedge clk);
        count_prohibited <= 1'h1;
        delta(50, 64'd0);
        cmp(evt_export, 8'h00);
        @(posedge clk);
        count_prohibited <= 1'h0;
        delta(20, 64'd20);
        cmp(evt_export, rv[15:8]);
        @(posedge clk);
        sys_wr <= 1'h1;
        sys_wdata <= 7'h09;
        @(posedge clk);
        sys_wr <= 1'h0;
        sys_wdata <= 7'h76;
        ctl = 7'h09;
        rd_chk(`PMC_CTRL_OFFSET, {25'h0, ctl});
        delta(640, 64'd10);
        cmp(evt_export, 8'h00);
        @(posedge clk);
        dbg_rst <= 1'h1;
        @(posedge clk);
        dbg_rst <= 1'h0;
        @(negedge clk);
        cmp(sys_rdata, ctl);
        w(7'h40);
        delta(30, 64'd0);
        @(negedge clk);
        cmp(evt_count_enable, {rv[30:5], 5'h00});
        exq.push_back({25'h0, ctl});
        u_dbg.rmw(`PMC_CTRL_OFFSET, 32'h0, 32'h1);
        @(posedge clk);
        count_prohibited <= 1'h1;
        delta(60, 64'd60);
        @(negedge clk);
        cmp(evt_count_enable, {rv[30:5], 5'h00});
        @(posedge clk);
        count_prohibited <= 1'h0;
        hyp_prohibit_bit <= 1'h1;
        @(negedge clk);
        cmp(evt_count_enable, {rv[30:5], 5'h00});
        @(posedge clk);
        hyp_prohibit_bit <= 1'h0;
        hyp_external_access_bit <= 1'h1;
        @(negedge clk);
        cmp(evt_count_enable, {rv[30:5], 5'h1f});
        w(7'h42);
        @(negedge clk);
        cmp(evt_counter_clear, 31'h1f);
        // counter holds a nonzero value here, so the clear is visible
        w(7'h0d);
        @(negedge clk);
        cmp(cycle_counter, 64'h0);
        cmp(sys_rdata, 7'h09);
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        cmp(sys_rdata, 7'h40);
        cmp(cycle_counter, 64'h0);
        repeat (4) @(negedge clk);
        cmp(exq.size(), 64'h0);
        end_sim();
    end
endmodule : perf_monitor_control_regs_bench
